// ===== common/sinc_pkg.sv
/*
 * Shared constants and carriers for the sinc3 decimation channel filter.
 * Assumes one system clock; modulator bits arrive from another domain.
 */
package sinc_pkg;
   localparam int         DIV_HIGH_RES    = 4;
   localparam int         DIV_LOW_POWER   = 8;
   localparam int         RESULT_W        = 24;
   localparam int         RATE_W          = 3;
   localparam int         GAIN_W          = 3;
   localparam int         SETTLE_PERIODS  = 3;
   localparam int         MAX_LOG2_RATIO  = 11;
   localparam int         ACC_W           = 3 * MAX_LOG2_RATIO + 2;
   localparam logic [2:0] GAIN_RST        = 3'h6;
   localparam logic [2:0] RATE_RST        = 3'h6;
   localparam logic [23:0] POS_FULL_SCALE = 24'h7fffff;
   localparam logic [23:0] NEG_FULL_SCALE = 24'h800000;
   localparam logic       REFBUF_PD_RST   = 1'b1;
   localparam logic       REF_HIGH_RST    = 1'b0;

   typedef struct packed {
      logic [RESULT_W-1:0] data;
      logic                valid;
   } result_t;

   typedef struct packed {
      logic refbuf_powerdown;
      logic ref_high_select;
   } ref_ctrl_t;
endpackage

// ===== design/sinc3_core.sv
/*
 * One channel of third-order sinc: three integrators at the modulator rate,
 * three combs at the decimated rate.
 * Assumes mod_en and dec_en are one-cycle enables from the parent.
 */
`timescale 1ns/10ps
`default_nettype none
module sinc3_core #(
   parameter int ACC_W = sinc_pkg::ACC_W
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             clear,
   input  wire logic             mod_en,
   input  wire logic             mod_bit,
   input  wire logic             dec_en,
   output logic      [ACC_W-1:0] comb_out
);
   logic [ACC_W-1:0] integ_r [3];
   logic [ACC_W-1:0] dly_r   [3];
   logic [ACC_W-1:0] stage   [4];
   logic [ACC_W-1:0] sample;

   // Bipolar input: 1 -> +1, 0 -> -1; wraparound arithmetic is exact in mod 2^ACC_W
   assign sample = mod_bit ? ACC_W'(1) : {ACC_W{1'b1}};

   always_ff @(posedge clk_sys) begin
      if (rst || clear) begin
         for (int i = 0; i < 3; i++) integ_r[i] <= '0;
      end else if (mod_en) begin
         integ_r[0] <= integ_r[0] + sample;
         integ_r[1] <= integ_r[1] + integ_r[0];
         integ_r[2] <= integ_r[2] + integ_r[1];
      end
   end

   assign stage[0] = integ_r[2];
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_comb
         assign stage[g+1] = stage[g] - dly_r[g];
         always_ff @(posedge clk_sys) begin
            if (rst || clear) begin
               dly_r[g] <= '0;
            end else if (dec_en) begin
               dly_r[g] <= stage[g];
            end
         end
      end
   endgenerate

   assign comb_out = stage[3];
endmodule
`default_nettype wire

// ===== design/sinc3_channel_filter.sv
/*
 * Multi-channel sinc3 decimation filter with rate, gain and reference control.
 * Assumes modulator bits come from outside the clock domain; control ports
 * come from logic on clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
module sinc3_channel_filter #(
   parameter int CHANNELS = 8
) (
   input  wire logic                          clk_sys,
   input  wire logic                          rst,
   input  wire logic                          start,
   input  wire logic                          low_power,
   input  wire logic [sinc_pkg::RATE_W-1:0]   rate_select,
   input  wire logic [CHANNELS*3-1:0]         channel_settings,
   input  wire logic                          ref_high_select,
   input  wire logic                          refbuf_powerdown,
   input  wire logic [CHANNELS-1:0]           mod_data,
   output sinc_pkg::result_t                  result [CHANNELS],
   output logic                               settled,
   output sinc_pkg::ref_ctrl_t                ref_ctrl
);
   localparam int AW = sinc_pkg::ACC_W;
   // Weight of full scale in the output word: N^3 lands on 2^23
   localparam logic [5:0] SHIFT_PT = 6'(sinc_pkg::RESULT_W - 1);

   // Log2 of decimation ratio per rate code; ratios 16..2048
   function automatic logic [3:0] ratio_log2(input logic [2:0] code);
      case (code)
         3'h0:    ratio_log2 = 4'h4;
         3'h1:    ratio_log2 = 4'h5;
         3'h2:    ratio_log2 = 4'h6;
         3'h3:    ratio_log2 = 4'h7;
         3'h4:    ratio_log2 = 4'h8;
         3'h5:    ratio_log2 = 4'h9;
         3'h6:    ratio_log2 = 4'ha;
         default: ratio_log2 = 4'hb;
      endcase
   endfunction

   // Gain code to multiplier; reserved code treated as unity
   function automatic logic [3:0] gain_mult(input logic [2:0] code);
      case (code)
         3'h0:    gain_mult = 4'h6;
         3'h1:    gain_mult = 4'h1;
         3'h2:    gain_mult = 4'h2;
         3'h3:    gain_mult = 4'h3;
         3'h4:    gain_mult = 4'h4;
         3'h5:    gain_mult = 4'h8;
         3'h6:    gain_mult = 4'hc;
         default: gain_mult = 4'h1;
      endcase
   endfunction

   typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_RUN} state_t;

   state_t            state_r;
   logic [2:0]        div_cnt_r;
   logic              mod_en_r;
   logic [10:0]       dec_cnt_r;
   logic              dec_en;
   logic [1:0]        settle_cnt_r;
   logic              start_r;
   logic              clear;
   logic [3:0]        ratio_l2_r;
   logic [5:0]        l2x3;
   logic [CHANNELS-1:0] mod_s1_r;
   logic [CHANNELS-1:0] mod_s2_r;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mod_s1_r <= '0;
         mod_s2_r <= '0;
      end else begin
         mod_s1_r <= mod_data;
         mod_s2_r <= mod_s1_r;
      end
   end

   // Divider: one modulator sample every 4 or 8 clocks
   always_ff @(posedge clk_sys) begin
      if (rst || clear) begin
         div_cnt_r <= '0;
         mod_en_r  <= 1'b0;
      end else begin
         mod_en_r <= (div_cnt_r == (low_power ? 3'(sinc_pkg::DIV_LOW_POWER - 1)
                                              : 3'(sinc_pkg::DIV_HIGH_RES - 1)));
         if (div_cnt_r == (low_power ? 3'(sinc_pkg::DIV_LOW_POWER - 1)
                                     : 3'(sinc_pkg::DIV_HIGH_RES - 1))) begin
            div_cnt_r <= '0;
         end else begin
            div_cnt_r <= div_cnt_r + 3'h1;
         end
      end
   end

   // Rate latched at start so a running conversion never changes ratio mid-word
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ratio_l2_r <= ratio_log2(sinc_pkg::RATE_RST);
      end else if (clear) begin
         ratio_l2_r <= ratio_log2(rate_select);
      end
   end
   assign l2x3 = 6'({2'h0, ratio_l2_r} * 6'h3);

   always_ff @(posedge clk_sys) begin
      if (rst || clear) begin
         dec_cnt_r <= '0;
      end else if (mod_en_r) begin
         dec_cnt_r <= dec_en ? 11'h0 : dec_cnt_r + 11'h1;
      end
   end
   assign dec_en = mod_en_r && (dec_cnt_r == 11'((12'h1 << ratio_l2_r) - 12'h1));

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         start_r <= 1'b0;
      end else begin
         start_r <= start;
      end
   end
   assign clear = start && !start_r;

   // Settling: discard three output words after a start edge
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_r      <= ST_IDLE;
         settle_cnt_r <= '0;
      end else if (clear) begin
         state_r      <= ST_SETTLE;
         settle_cnt_r <= '0;
      end else begin
         case (state_r)
            ST_IDLE: state_r <= ST_IDLE;
            ST_SETTLE: begin
               if (dec_en) begin
                  if (settle_cnt_r == 2'(sinc_pkg::SETTLE_PERIODS - 1)) begin
                     state_r <= ST_RUN;
                  end
                  settle_cnt_r <= settle_cnt_r + 2'h1;
               end
            end
            ST_RUN:  state_r <= ST_RUN;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         settled <= 1'b0;
      end else begin
         settled <= (state_r == ST_RUN);
      end
   end

   genvar c;
   generate
      for (c = 0; c < CHANNELS; c++) begin : g_ch
         logic [AW-1:0]   comb;
         logic [AW+3:0]   scaled;
         logic signed [AW+3:0] s_val;
         logic [23:0]     word;

         sinc3_core #(.ACC_W(AW)) u_core (
            .clk_sys  (clk_sys),
            .rst      (rst),
            .clear    (clear),
            .mod_en   (mod_en_r),
            .mod_bit  (mod_s2_r[c]),
            .dec_en   (dec_en),
            .comb_out (comb)
         );

         // Gain applied digitally; full scale of N^3 mapped to 2^23
         assign scaled = (AW+4)'($signed(comb) * $signed({1'b0, gain_mult(channel_settings[c*3 +: 3])}));
         // Small ratios give fewer than 23 bits of growth, so they shift left
         assign s_val  = (l2x3 >= SHIFT_PT) ? ($signed(scaled) >>> (l2x3 - SHIFT_PT))
                                            : ($signed(scaled) <<< (SHIFT_PT - l2x3));

         always_comb begin
            if (s_val > $signed((AW+4)'(sinc_pkg::POS_FULL_SCALE))) begin
               word = sinc_pkg::POS_FULL_SCALE;
            end else if (s_val < -$signed((AW+4)'(24'h800000))) begin
               word = sinc_pkg::NEG_FULL_SCALE;
            end else begin
               word = s_val[23:0];
            end
         end

         always_ff @(posedge clk_sys) begin
            if (rst) begin
               result[c] <= '0;
            end else begin
               // A boundary landing on the start edge belongs to the old run
               result[c].valid <= dec_en && (state_r == ST_RUN) && !clear;
               if (dec_en) begin
                  result[c].data <= word;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ref_ctrl.refbuf_powerdown <= sinc_pkg::REFBUF_PD_RST;
         ref_ctrl.ref_high_select  <= sinc_pkg::REF_HIGH_RST;
      end else begin
         ref_ctrl.refbuf_powerdown <= refbuf_powerdown;
         ref_ctrl.ref_high_select  <= ref_high_select;
      end
   end
endmodule
`default_nettype wire

// ===== dv/sinc3_channel_filter_checker.sv
/* Port checker for the sinc3 filter top.
   Assumes it is bound to the filter and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module sinc3_channel_filter_checker #(
   parameter int CHANNELS = 8
) (
   input wire logic                clk_sys,
   input wire logic                rst,
   input wire logic                start,
   input wire logic                ref_high_select,
   input wire logic                refbuf_powerdown,
   input wire sinc_pkg::result_t   result [CHANNELS],
   input wire logic                settled,
   input wire sinc_pkg::ref_ctrl_t ref_ctrl
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_valid_gap; result[0].valid |=> !result[0].valid [*8]; endproperty
   a_valid_gap: assert property (p_valid_gap) else $error("valid pulses too close");
   property p_valid_settled; result[0].valid |-> settled; endproperty
   a_valid_settled: assert property (p_valid_settled) else $error("valid before settling");
   property p_channels_sync; result[0].valid == result[CHANNELS-1].valid; endproperty
   a_channels_sync: assert property (p_channels_sync) else $error("channels out of step");
   property p_settle_first; $rose(settled) |-> !result[0].valid; endproperty
   a_settle_first: assert property (p_settle_first) else $error("settled raised on a data word");
   property p_settled_hold; settled && !start |=> settled; endproperty
   a_settled_hold: assert property (p_settled_hold) else $error("settled dropped");
   property p_reset_vals; $fell(rst) |-> !settled && !result[0].valid && ref_ctrl == 2'b10; endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("wrong values after reset");
   property p_ref_high; 1'b1 |=> ref_ctrl.ref_high_select == $past(ref_high_select); endproperty
   a_ref_high: assert property (p_ref_high) else $error("reference select not followed");
   property p_refbuf; 1'b1 |=> ref_ctrl.refbuf_powerdown == $past(refbuf_powerdown); endproperty
   a_refbuf: assert property (p_refbuf) else $error("buffer power-down not followed");
   property p_start_drop; start && !$past(start) |-> ##[1:2] !settled; endproperty
   a_start_drop: assert property (p_start_drop) else $error("settled kept over restart");
endmodule
bind sinc3_channel_filter sinc3_channel_filter_checker #(.CHANNELS(CHANNELS)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .start(start), .ref_high_select(ref_high_select),
   .refbuf_powerdown(refbuf_powerdown), .result(result), .settled(settled), .ref_ctrl(ref_ctrl));
`default_nettype wire

// ===== dv/mod_source.sv
/* Behavioural modulator: one bit per channel per modulator period.
   Assumes level is the wanted sign of each channel's input. */
`timescale 1ns/10ps
`default_nettype none
module mod_source #(
   parameter int CHANNELS = 2
) (
   input wire logic                clk_sys,
   input wire logic                low_power,
   input wire logic [CHANNELS-1:0] level,
   output logic     [CHANNELS-1:0] mod_data
);
   int div_cnt = 0;
   initial mod_data = '0;
   // New bit every 4 or 8 clocks, free running like the real modulator
   always @(posedge clk_sys) begin
      div_cnt <= (div_cnt >= (low_power ? 7 : 3)) ? 0 : div_cnt + 1;
      if (div_cnt == 0) begin
         mod_data <= level;
      end
   end
endmodule
`default_nettype wire

// ===== dv/sinc3_channel_filter_test.sv
/* Self-checking bench for the sinc3 filter.
   Assumes the modulator model in mod_source and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module sinc3_channel_filter_test;
   localparam int CH = 2;
   logic              clk_sys, rst, start, low_power, ref_high_select, refbuf_powerdown, settled;
   logic [2:0]        rate_select;
   logic [CH*3-1:0]   channel_settings;
   logic [CH-1:0]     level, mod_data;
   sinc_pkg::result_t result [CH];
   sinc_pkg::ref_ctrl_t ref_ctrl;
   int                errors, checked, cycles, n, sp;
   logic [2:0]        rate_tab [4] = '{3'h0, 3'h0, 3'h1, 3'h4};
   logic              lp_tab [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
   int                gain_tab [8] = '{6, 1, 2, 3, 4, 8, 12, 1};
   logic              pat_on;
   sinc3_channel_filter #(.CHANNELS(CH)) DUT (.clk_sys(clk_sys), .rst(rst), .start(start),
      .low_power(low_power), .rate_select(rate_select), .channel_settings(channel_settings),
      .ref_high_select(ref_high_select), .refbuf_powerdown(refbuf_powerdown), .mod_data(mod_data),
      .result(result), .settled(settled), .ref_ctrl(ref_ctrl));
   // Pattern: 17 of every 32 modulator periods high, a mean of 1/16
   mod_source #(.CHANNELS(CH)) MOD (.clk_sys(clk_sys), .low_power(low_power),
      .level(pat_on ? {CH{(cycles[6:0] < 7'h44)}} : level), .mod_data(mod_data));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results;
      if (errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Registered outputs are read 1 ns after the edge
   task automatic wait_valid(output int cnt);
      cnt = 0;
      do begin
         @(posedge clk_sys);
         #1;
         cnt++;
      end while (result[0].valid !== 1'b1 && cnt < 5000);
   endtask
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         results();
      end
   end
   initial begin
      rst = 1'b1; start = 1'b0; low_power = 1'b0; rate_select = 3'h0;
      channel_settings = 6'h31; // Gain x1 on channel 0, x12 on channel 1
      ref_high_select = 1'b0; refbuf_powerdown = 1'b1; level = 2'h1;
      errors = 0; checked = 0; cycles = 0; pat_on = 1'b0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      check(ref_ctrl, 32'h2);
      check(settled, 32'h0);
      @(posedge clk_sys);
      ref_high_select <= 1'b1;
      refbuf_powerdown <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      check(ref_ctrl, 32'h1);
      for (int i = 0; i < 4; i++) begin
         sp = (16 << rate_tab[i]) * (lp_tab[i] ? 8 : 4);
         @(posedge clk_sys);
         start <= 1'b0;
         low_power <= lp_tab[i];
         rate_select <= rate_tab[i];
         @(posedge clk_sys);
         start <= 1'b1;
         wait_valid(n);
         check(n > 3 * sp && n <= 4 * sp + 8, 32'h1);
         check(settled, 32'h1);
         wait_valid(n);
         check(n, sp);
         check(result[0].data, sinc_pkg::POS_FULL_SCALE);
         check(result[1].data, sinc_pkg::NEG_FULL_SCALE);
      end
      // Step lands between boundaries, so allow a fourth word
      level <= 2'h2;
      repeat (4) wait_valid(n);
      check(result[0].data, sinc_pkg::NEG_FULL_SCALE);
      check(result[1].data, sinc_pkg::POS_FULL_SCALE);
      // Ratio 32, mean 1/16: each unit of gain is worth 0x080000
      pat_on <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys);
         start <= 1'b0;
         low_power <= 1'b0;
         rate_select <= 3'h1;
         channel_settings <= {3'(7 - k), 3'(k)};
         @(posedge clk_sys);
         start <= 1'b1;
         wait_valid(n);
         check(result[0].data, 32'h80000 * gain_tab[k]);
         check(result[1].data, 32'h80000 * gain_tab[7 - k]);
      end
      results();
   end
endmodule
`default_nettype wire
